/* rtl/tmr_timer_top.sv */
// Eight-bit compare/PWM timer with two output channels and a top value.
// Assumes an Avalon-MM master on mclk_in and a fast peripheral clock arriving as a pin.
// Function
// - Async enable selects fast clock, else system clock.
// - Written values pass sync stage before use.
// - Control and compare registers read back immediately.
// - Count and flags read back after sync delay.
// - Counter runs from fast clock well under half of mclk_in.
// - Three flags in flag register, enables in mask.
// - Normal mode compares all three values continuously.
// - Match A/B drive output and flag A/B.
// - Third compare register holds the counter top.
// - Wrap flag on FF-to-zero or top-to-zero.
// - Inverted outputs disconnected in normal mode.
// - PWM mode counts to top then restarts.
// - PWM matches produce true output, inverted too in toggle mode only.
// - Channel A mode: off, toggle, clear, set.
// - Channel B mode: off, toggle, clear, set.
// - Force A applies action, no flag, reads zero.
// - Force B applies action, no flag, reads zero.
// - Force ignored while channel PWM enabled.
// - PWM A enable clears counter after top.
// - PWM B enable clears counter after top.
// - Clear-on-top zeroes counter one cycle after top.
// - Software write onto compare value gives no match.
// - Clock select stops or divides by 2^(n-1).
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module tmr_timer_top
  import tmr_pkg::*;
(
  input wire logic mclk_in, // System clock, 125 MHz
  input wire logic rst_n_in, // Async reset, active low
  input wire logic [TMR_AW-1:0] avs_address_in, // Byte address
  input wire logic avs_read_in, // Read request
  input wire logic avs_write_in, // Write request
  input wire logic [31:0] avs_writedata_in, // Write data, low byte used
  input wire logic [3:0] avs_byteenable_in, // Byte lanes
  output logic [31:0] avs_readdata_out, // Read data, upper bits zero
  output logic avs_waitrequest_out, // Stall until answer
  input wire logic fast_periph_clock_in, // Fast peripheral clock pin
  output logic compare_out_a_out, // Channel A true output
  output logic compare_out_a_en_out, // Channel A true output connected
  output logic compare_out_a_n_out, // Channel A inverted output
  output logic compare_out_a_n_en_out, // Channel A inverted output connected
  output logic compare_out_b_out, // Channel B true output
  output logic compare_out_b_en_out, // Channel B true output connected
  output logic compare_out_b_n_out, // Channel B inverted output
  output logic compare_out_b_n_en_out // Channel B inverted output connected
);
  logic [7:0] ctrl_a_reg, ctrl_b_reg, cmp_a_reg, cmp_b_reg, top_reg;
  logic [7:0] flag_reg, mask_reg;
  logic async_reg;
  logic ack_reg;
  logic [7:0] rdata_reg;
  logic take, wr_hit;
  logic [7:0] wbyte;
  logic [7:0] rd_next;
  logic force_a_wr, force_b_wr, cnt_wr, pre_rst_wr;
  logic [7:0] ctrl_a_si, ctrl_b_si, cmp_a_si, cmp_b_si, top_si;
  logic async_si;
  logic force_a_si, force_b_si, cnt_wr_si, pre_rst_si, force_a_d_reg, force_b_d_reg;
  logic [7:0] cnt_wr_val_si;
  logic fp_s1_reg, fp_s2_reg, fp_s3_reg, fp_lvl_reg, fast_rise;
  logic base_tick, tick;
  logic [7:0] count_reg, adv_val;
  logic adv, top_hit_reg, clr_top, wrap_evt;
  logic [1:0] hit;
  logic [7:0] count_so;
  logic [2:0] evt_so;
  logic [1:0] out_reg, out_en_reg, out_n_en_reg;

  // Bus slave: one wait cycle, request taken when waitrequest is low
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
  assign take = (avs_read_in || avs_write_in) && ack_reg;
  assign wr_hit = take && avs_write_in && avs_byteenable_in[0];
  assign wbyte = avs_writedata_in[7:0];
  assign avs_readdata_out = {24'h000000, rdata_reg};

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= avs_waitrequest_out;
    end
  end

  // Control and compare registers read back their stored value at once
  always_comb begin
    case (avs_address_in)
      OFS_CTRL_A: rd_next = ctrl_a_reg & CTRL_A_RD_MASK;
      OFS_CTRL_B: rd_next = ctrl_b_reg & CTRL_B_RD_MASK;
      OFS_COUNT: rd_next = count_so;
      OFS_CMP_A: rd_next = cmp_a_reg;
      OFS_CMP_B: rd_next = cmp_b_reg;
      OFS_TOP: rd_next = top_reg;
      OFS_FLAG: rd_next = flag_reg;
      OFS_MASK: rd_next = mask_reg;
      OFS_PLL: rd_next = {5'h00, async_reg, 2'h0};
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 8'h00;
    end else if (avs_read_in && !ack_reg) begin
      rdata_reg <= rd_next;
    end
  end

  // Force and prescaler-reset bits are strobes and never stored
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_a_reg <= CTRL_A_RST;
      ctrl_b_reg <= CTRL_B_RST;
      cmp_a_reg <= CMP_RST;
      cmp_b_reg <= CMP_RST;
      top_reg <= CMP_RST;
      mask_reg <= 8'h00;
      async_reg <= 1'b0;
    end else if (wr_hit) begin
      case (avs_address_in)
        OFS_CTRL_A: ctrl_a_reg <= wbyte & CTRL_A_RD_MASK;
        OFS_CTRL_B: ctrl_b_reg <= wbyte & CTRL_B_RD_MASK;
        OFS_CMP_A: cmp_a_reg <= wbyte;
        OFS_CMP_B: cmp_b_reg <= wbyte;
        OFS_TOP: top_reg <= wbyte;
        OFS_MASK: mask_reg <= wbyte & FLAG_MASK_BITS;
        OFS_PLL: async_reg <= wbyte[PLL_ASYNC];
        default: ;
      endcase
    end
  end

  assign force_a_wr = wr_hit && (avs_address_in == OFS_CTRL_A) && wbyte[CA_FORCE_A]
                      && !wbyte[CA_PWM_A];
  assign force_b_wr = wr_hit && (avs_address_in == OFS_CTRL_A) && wbyte[CA_FORCE_B]
                      && !wbyte[CA_PWM_B];
  assign cnt_wr = wr_hit && (avs_address_in == OFS_COUNT);
  assign pre_rst_wr = wr_hit && (avs_address_in == OFS_CTRL_B) && wbyte[CB_PRE_RST];

  // Every register value and write strobe the counter sees passes one input sync stage; the fast clock pin has its own synchroniser
  tmr_sync_stage #(.W(53)) u_in_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in({ctrl_a_reg, ctrl_b_reg, cmp_a_reg, cmp_b_reg, top_reg, async_reg,
           force_a_wr, force_b_wr, cnt_wr, pre_rst_wr, wbyte}),
    .q_out({ctrl_a_si, ctrl_b_si, cmp_a_si, cmp_b_si, top_si, async_si,
            force_a_si, force_b_si, cnt_wr_si, pre_rst_si, cnt_wr_val_si})
  );

  // Force waits one more cycle so the mode written with it is already on the counter side
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      force_a_d_reg <= 1'b0;
      force_b_d_reg <= 1'b0;
    end else begin
      force_a_d_reg <= force_a_si;
      force_b_d_reg <= force_b_si;
    end
  end

  // Fast clock pin: first flop feeds only the second; edge once stages two and three agree
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fp_s1_reg <= 1'b0;
      fp_s2_reg <= 1'b0;
      fp_s3_reg <= 1'b0;
      fp_lvl_reg <= 1'b0;
    end else begin
      fp_s1_reg <= fast_periph_clock_in;
      fp_s2_reg <= fp_s1_reg;
      fp_s3_reg <= fp_s2_reg;
      if (fp_s2_reg == fp_s3_reg) begin
        fp_lvl_reg <= fp_s3_reg;
      end
    end
  end

  assign fast_rise = (fp_s2_reg == fp_s3_reg) && fp_s3_reg && !fp_lvl_reg;
  // Sampling limits the usable fast clock to well under half of mclk_in
  assign base_tick = async_si ? fast_rise : 1'b1;

  tmr_prescaler u_pre (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .base_tick_in(base_tick),
    .pre_clear_in(pre_rst_si),
    .sel_in(ctrl_b_si[CB_CS_LSB +: CB_CS_W]),
    .tick_out(tick)
  );

  // Top match clears one cycle later when clear-on-top or either PWM is on
  assign clr_top = top_hit_reg && (ctrl_b_si[CB_CLR_TOP] || ctrl_a_si[CA_PWM_A]
                   || ctrl_a_si[CA_PWM_B]);
  // A software write to the count never counts as counting onto a value
  assign adv = !cnt_wr_si && (clr_top || tick);
  assign adv_val = clr_top ? 8'h00 : count_reg + 8'h01;
  assign wrap_evt = adv && (adv_val == 8'h00);
  assign hit[0] = adv && (adv_val == cmp_a_si);
  assign hit[1] = adv && (adv_val == cmp_b_si);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= COUNT_RST;
    end else if (cnt_wr_si) begin
      count_reg <= cnt_wr_val_si;
    end else if (adv) begin
      count_reg <= adv_val;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      top_hit_reg <= 1'b0;
    end else begin
      top_hit_reg <= adv && !clr_top && (adv_val == top_si);
    end
  end

  // Output sync stage: readers see count and events one cycle late
  tmr_sync_stage #(.W(11)) u_out_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in({count_reg, hit, wrap_evt}),
    .q_out({count_so, evt_so})
  );

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_reg <= 8'h00;
    end else begin
      flag_reg[FLG_CMP_A] <= evt_so[1] || (flag_reg[FLG_CMP_A]
                             && !(wr_hit && avs_address_in == OFS_FLAG && wbyte[FLG_CMP_A]));
      flag_reg[FLG_CMP_B] <= evt_so[2] || (flag_reg[FLG_CMP_B]
                             && !(wr_hit && avs_address_in == OFS_FLAG && wbyte[FLG_CMP_B]));
      flag_reg[FLG_WRAP] <= evt_so[0] || (flag_reg[FLG_WRAP]
                            && !(wr_hit && avs_address_in == OFS_FLAG && wbyte[FLG_WRAP]));
    end
  end

  // Output channels; index 0 is A, index 1 is B
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [1:0] mode;
    logic pwm_on, frc;
    assign mode = (i == 0) ? ctrl_a_si[CA_MODE_A_LSB +: 2] : ctrl_a_si[CA_MODE_B_LSB +: 2];
    assign pwm_on = (i == 0) ? ctrl_a_si[CA_PWM_A] : ctrl_a_si[CA_PWM_B];
    assign frc = (i == 0) ? force_a_d_reg : force_b_d_reg;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        out_reg[i] <= 1'b0;
      end else if (pwm_on) begin
        if (hit[i]) begin
          out_reg[i] <= 1'b0;
        end else if (wrap_evt) begin
          out_reg[i] <= 1'b1;
        end
      end else if (hit[i] || frc) begin
        case (mode)
          MODE_TOGGLE: out_reg[i] <= !out_reg[i];
          MODE_CLEAR: out_reg[i] <= 1'b0;
          MODE_SET: out_reg[i] <= 1'b1;
          default: out_reg[i] <= out_reg[i];
        endcase
      end
    end

    // Pin drive itself also needs the port direction set by software
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        out_en_reg[i] <= 1'b0;
        out_n_en_reg[i] <= 1'b0;
      end else begin
        out_en_reg[i] <= (mode != MODE_OFF);
        out_n_en_reg[i] <= pwm_on && (mode == MODE_TOGGLE);
      end
    end
  end

  assign compare_out_a_out = out_reg[0];
  assign compare_out_a_en_out = out_en_reg[0];
  assign compare_out_a_n_out = !out_reg[0];
  assign compare_out_a_n_en_out = out_n_en_reg[0];
  assign compare_out_b_out = out_reg[1];
  assign compare_out_b_en_out = out_en_reg[1];
  assign compare_out_b_n_out = !out_reg[1];
  assign compare_out_b_n_en_out = out_n_en_reg[1];

  property p_async_hold;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (async_si && !fast_rise && !clr_top && !cnt_wr_si) |=> $stable(count_reg);
  endproperty
  a_async_hold: assert property (p_async_hold) else $error("count moved without fast edge");

  property p_in_sync;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (wr_hit && avs_address_in == OFS_CMP_A)
        |=> $stable(cmp_a_si) ##1 (cmp_a_si == $past(wbyte, 2));
  endproperty
  a_in_sync: assert property (p_in_sync) else $error("compare A not staged one cycle later");

  property p_readback;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (wr_hit && avs_address_in == OFS_CMP_B) |=> (cmp_b_reg == $past(wbyte));
  endproperty
  a_readback: assert property (p_readback) else $error("compare B not stored");

  property p_count_delay;
    @(posedge mclk_in) disable iff (!rst_n_in)
      cnt_wr_si |-> ##2 (count_so == $past(cnt_wr_val_si, 2));
  endproperty
  a_count_delay: assert property (p_count_delay) else $error("count readback latency wrong");

  property p_wrap_flag;
    @(posedge mclk_in) disable iff (!rst_n_in)
      wrap_evt |-> ##2 flag_reg[FLG_WRAP];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag not raised");

  property p_no_soft_match;
    @(posedge mclk_in) disable iff (!rst_n_in)
      cnt_wr_si |-> (hit == 2'b00) && !wrap_evt;
  endproperty
  a_no_soft_match: assert property (p_no_soft_match) else $error("match from software write");

  property p_clear_top;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (top_hit_reg && ctrl_b_si[CB_CLR_TOP] && !cnt_wr_si) |=> (count_reg == 8'h00);
  endproperty
  a_clear_top: assert property (p_clear_top) else $error("no clear after top match");

  property p_force_set;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (force_a_d_reg && !ctrl_a_si[CA_PWM_A] && ctrl_a_si[CA_MODE_A_LSB +: 2] == MODE_SET)
        |=> compare_out_a_out;
  endproperty
  a_force_set: assert property (p_force_set) else $error("force set did not set output");

  property p_stop;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (ctrl_b_si[CB_CS_LSB +: CB_CS_W] == 4'h0 && !clr_top && !cnt_wr_si) |=> $stable(count_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");

  property p_inv_off;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !ctrl_a_si[CA_PWM_A] |=> !compare_out_a_n_en_out;
  endproperty
  a_inv_off: assert property (p_inv_off) else $error("inverted A connected in normal mode");

  c_hit_a: cover property (@(posedge mclk_in) disable iff (!rst_n_in) hit[0] && !ctrl_a_si[CA_PWM_A]);
  c_pwm_wrap: cover property (@(posedge mclk_in) disable iff (!rst_n_in) clr_top && ctrl_a_si[CA_PWM_A]);
  c_async: cover property (@(posedge mclk_in) disable iff (!rst_n_in) async_si && tick);
  c_force_b: cover property (@(posedge mclk_in) disable iff (!rst_n_in) force_b_d_reg);
endmodule // tmr_timer_top
`default_nettype wire

/* rtl/tmr_pkg.sv */
// Register map, field positions, reset values and codes for the compare/PWM timer.
// Assumes a 32-bit Avalon-MM slave with byte addresses; all registers are 8 bits wide.
package tmr_pkg;
  localparam int TMR_AW = 8;
  localparam int TMR_DW = 8;
  localparam int TMR_PRE_W = 14;
  localparam logic [7:0] OFS_CTRL_A = 8'h30;
  localparam logic [7:0] OFS_CTRL_B = 8'h34;
  localparam logic [7:0] OFS_COUNT = 8'h38;
  localparam logic [7:0] OFS_CMP_A = 8'h3C;
  localparam logic [7:0] OFS_CMP_B = 8'h40;
  localparam logic [7:0] OFS_TOP = 8'h44;
  localparam logic [7:0] OFS_FLAG = 8'h48;
  localparam logic [7:0] OFS_MASK = 8'h4C;
  localparam logic [7:0] OFS_PLL = 8'h50;
  localparam int CA_MODE_A_LSB = 6;
  localparam int CA_MODE_B_LSB = 4;
  localparam int CA_FORCE_A = 3;
  localparam int CA_FORCE_B = 2;
  localparam int CA_PWM_A = 1;
  localparam int CA_PWM_B = 0;
  localparam int CB_CLR_TOP = 7;
  localparam int CB_PRE_RST = 6;
  localparam int CB_CS_LSB = 0;
  localparam int CB_CS_W = 4;
  localparam int PLL_ASYNC = 2;
  localparam int FLG_CMP_A = 6;
  localparam int FLG_CMP_B = 5;
  localparam int FLG_WRAP = 2;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] FLAG_MASK_BITS = 8'h64;
  localparam logic [7:0] CTRL_A_RD_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_RD_MASK = 8'h8F;
  localparam logic [7:0] PLL_RD_MASK = 8'h04;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TOGGLE = 2'h1;
  localparam logic [1:0] MODE_CLEAR = 2'h2;
  localparam logic [1:0] MODE_SET = 2'h3;
  localparam int SYS_CLK_MHZ = 125;
  localparam int FAST_CLK_MAX_MHZ = 64;
endpackage

/* rtl/tmr_sync_stage.sv */
// One synchronisation register stage between the register file and the counter.
// Assumes both sides run on the same clock; adds exactly one cycle of latency.
`timescale 1ns/10ps
`default_nettype none
module tmr_sync_stage #(
  parameter int W = 8
) (
  input wire logic mclk_in, // System clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic [W-1:0] d_in, // Value from the source side
  output logic [W-1:0] q_out // Value one cycle later
);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_out <= '0;
    end else begin
      q_out <= d_in;
    end
  end
endmodule // tmr_sync_stage
`default_nettype wire

/* rtl/tmr_prescaler.sv */
// Prescaler: divides the base tick by 2^(n-1) for select code n, stops at code 0.
// Assumes base_tick_in is a one-cycle pulse per base clock edge.
`timescale 1ns/10ps
`default_nettype none
module tmr_prescaler
  import tmr_pkg::*;
(
  input wire logic mclk_in, // System clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic base_tick_in, // One pulse per base clock edge
  input wire logic pre_clear_in, // Restart the division chain
  input wire logic [CB_CS_W-1:0] sel_in, // Clock-select code
  output logic tick_out // Prescaled tick, one cycle
);
  logic [TMR_PRE_W-1:0] pre_reg;
  logic [TMR_PRE_W-1:0] div_mask;

  always_comb begin
    div_mask = '0;
    if (sel_in != '0) begin
      div_mask = TMR_PRE_W'((15'h0001 << (sel_in - 4'h1)) - 15'h0001);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_reg <= '0;
    end else if (pre_clear_in) begin
      pre_reg <= '0;
    end else if (base_tick_in) begin
      pre_reg <= pre_reg + TMR_PRE_W'(1);
    end
  end

  // Stop at code 0, otherwise base tick gated by the low divider bits
  assign tick_out = (sel_in != '0) && base_tick_in && ((pre_reg & div_mask) == div_mask);
endmodule // tmr_prescaler
`default_nettype wire

/* verification/tmr_pin_load.sv */
// Load model for one timer compare output pin: a port pin with its direction bit.
// Assumes the bench sets the direction bit; the pin has no pull resistor.
`timescale 1ns/10ps
`default_nettype none
module tmr_pin_load (
  input wire logic mclk_in, // System clock
  input wire logic dir_in, // Port direction, 1 = output
  input wire logic en_in, // Timer output connected to the pin
  input wire logic drive_in, // Level from the timer
  output logic pin_out // Level seen by the load
);
  logic last_reg = 1'b0;
  logic live;
  assign live = dir_in & en_in;
  always_ff @(posedge mclk_in) begin
    if (live) begin
      last_reg <= drive_in;
    end
  end
  // An undriven pin shows the opposite of its last level, so a stale value never passes
  assign pin_out = live ? drive_in : ~last_reg;
endmodule // tmr_pin_load
`default_nettype wire

/* verification/dual_clock_timer_compare_pwm_tb.sv */
// Self-checking bench for the compare/PWM timer: registers, forces, counting, PWM.
// Assumes the timer top and the pin load model; system clock plus a free fast pin clock.
`timescale 1ns/10ps
`default_nettype none
module dual_clock_timer_compare_pwm_tb
  import tmr_pkg::*;
();
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic fclk = 1'b0;
  logic dir = 1'b0;
  logic [31:0] rdata, q;
  logic wreq, oa, oa_en, oa_n, oa_n_en, ob, ob_en, ob_n, ob_n_en, pin_a, pin_b;
  logic [7:0] top, ca, cb, fl;
  logic [7:0] ofs_tab [5] = '{OFS_CMP_A, OFS_CMP_B, OFS_TOP, OFS_MASK, OFS_CTRL_B};
  logic [7:0] msk_tab [5] = '{8'hFF, 8'hFF, 8'hFF, FLAG_MASK_BITS, CTRL_B_RD_MASK};
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int take_cyc, dc, dt, hi_a, hi_b;
  integer seed = 32'hC9E5A472;

  tmr_timer_top dut_u (.mclk_in(mclk), .rst_n_in(rst_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .fast_periph_clock_in(fclk),
    .compare_out_a_out(oa), .compare_out_a_en_out(oa_en), .compare_out_a_n_out(oa_n),
    .compare_out_a_n_en_out(oa_n_en), .compare_out_b_out(ob), .compare_out_b_en_out(ob_en),
    .compare_out_b_n_out(ob_n), .compare_out_b_n_en_out(ob_n_en));
  tmr_pin_load load_a_u (.mclk_in(mclk), .dir_in(dir), .en_in(oa_en), .drive_in(oa),
    .pin_out(pin_a));
  tmr_pin_load load_b_u (.mclk_in(mclk), .dir_in(dir), .en_in(ob_en), .drive_in(ob),
    .pin_out(pin_b));

  initial begin
    forever #4 mclk = ~mclk;
  end
  // Fast clock about 24.6 MHz: each level must span two samples of the pin synchroniser
  initial begin
    #3.7;
    forever #20.3 fclk = ~fclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input int got, input int exp, input int tol);
    check_count++;
    if (got < exp - tol || got > exp + tol) begin
      bad_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Entered at a rising edge; request held until the rising edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= {24'h000000, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge mclk);
    end while (wreq !== 1'b0);
    q = rdata;
    take_cyc = cyc;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic force_one(input logic ch, input logic [1:0] m, input logic pwm);
    logic old, expv;
    logic [7:0] c;
    @(negedge mclk);
    old = ch ? ob : oa;
    @(posedge mclk);
    c = ch ? {2'b00, m, 2'b01, 1'b0, pwm} : {m, 2'b00, 2'b10, pwm, 1'b0};
    xfer(1'b1, OFS_CTRL_A, c);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    expv = (pwm || m == MODE_OFF) ? old : (m == MODE_TOGGLE) ? ~old : (m == MODE_SET);
    chk(ch ? ob : oa, expv);
    chk(ch ? ob_en : oa_en, m != MODE_OFF);
    chk(ch ? ob_n_en : oa_n_en, pwm && m == MODE_TOGGLE);
    @(posedge mclk);
    xfer(1'b0, OFS_CTRL_A, 8'h00);
    chk(q, {24'h0, c & CTRL_A_RD_MASK});
  endtask

  task automatic meas(input int gap);
    logic [7:0] c1;
    int t1;
    xfer(1'b0, OFS_COUNT, 8'h00);
    c1 = q[7:0];
    t1 = take_cyc;
    repeat (gap) @(posedge mclk);
    xfer(1'b0, OFS_COUNT, 8'h00);
    dc = (q[7:0] - c1) & 255;
    dt = take_cyc - t1;
  endtask

  task automatic burst(input logic [7:0] start, input logic [7:0] cbv);
    xfer(1'b1, OFS_COUNT, start);
    repeat (4) @(posedge mclk);
    xfer(1'b1, OFS_FLAG, FLAG_MASK_BITS);
    xfer(1'b1, OFS_CTRL_B, cbv);
    repeat (8) @(posedge mclk);
    xfer(1'b1, OFS_CTRL_B, 8'h00);
    repeat (6) @(posedge mclk);
    xfer(1'b0, OFS_FLAG, 8'h00);
    fl = q[7:0];
    xfer(1'b0, OFS_COUNT, 8'h00);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      xfer(1'b0, OFS_CTRL_A + 8'(4 * i), 8'h00);
      chk(q, 32'h0);
    end
    xfer(1'b1, 8'h5C, 8'hA5);
    xfer(1'b0, 8'h5C, 8'h00);
    chk(q, 32'h0);
    $display("test reset done");
    for (int ch = 0; ch < 2; ch++) begin
      force_one(ch[0], MODE_SET, 1'b0);
      force_one(ch[0], MODE_TOGGLE, 1'b0);
      force_one(ch[0], MODE_CLEAR, 1'b0);
      force_one(ch[0], MODE_TOGGLE, 1'b0);
      force_one(ch[0], MODE_OFF, 1'b0);
      force_one(ch[0], MODE_TOGGLE, 1'b1);
    end
    xfer(1'b0, OFS_FLAG, 8'h00);
    chk(q, 32'h0);
    xfer(1'b1, OFS_CTRL_A, 8'h00);
    $display("test force done");
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 5; i++) begin
        ca = $random(seed);
        xfer(1'b1, ofs_tab[i], ca);
        xfer(1'b0, ofs_tab[i], 8'h00);
        chk(q, {24'h0, ca & msk_tab[i]});
      end
    end
    xfer(1'b1, OFS_CTRL_B, 8'h00);
    xfer(1'b1, OFS_CMP_A, 8'h11);
    be <= 4'h0;
    xfer(1'b1, OFS_CMP_A, 8'h5A);
    be <= 4'hF;
    xfer(1'b0, OFS_CMP_A, 8'h00);
    chk(q, 32'h11);
    $display("test readback done");
    xfer(1'b1, OFS_CMP_A, 8'h37);
    xfer(1'b1, OFS_CMP_B, 8'h37);
    xfer(1'b1, OFS_TOP, 8'h37);
    xfer(1'b1, OFS_COUNT, 8'h37);
    repeat (4) @(posedge mclk);
    xfer(1'b1, OFS_FLAG, FLAG_MASK_BITS);
    repeat (6) @(posedge mclk);
    xfer(1'b0, OFS_FLAG, 8'h00);
    chk(q, 32'h0);
    xfer(1'b0, OFS_COUNT, 8'h00);
    chk(q, 32'h37);
    burst(8'h34, 8'h01);
    chk_near(q, 62, 3);
    chk({24'h0, fl & 8'h60}, 32'h60);
    burst(8'hFD, 8'h01);
    chk_near(q, 7, 3);
    chk({24'h0, fl & 8'h04}, 32'h04);
    xfer(1'b1, OFS_CMP_B, 8'h99);
    burst(8'h30, 8'h81);
    chk_near(q, 2, 3);
    chk({24'h0, fl & 8'h64}, 32'h44);
    $display("test counting done");
    for (int n = 0; n < 5; n++) begin
      xfer(1'b1, OFS_CTRL_B, 8'(n));
      meas(120);
      chk_near(dc, n == 0 ? 0 : dt >> (n - 1), 1);
    end
    xfer(1'b1, OFS_PLL, 8'hFF);
    xfer(1'b0, OFS_PLL, 8'h00);
    chk(q, {24'h0, PLL_RD_MASK});
    xfer(1'b1, OFS_CTRL_B, 8'h01);
    meas(200);
    chk_near(dc, dt * 80 / 406, 2);
    xfer(1'b1, OFS_PLL, 8'h00);
    $display("test clocking done");
    top = ($random(seed) & 8'h0F) + 8'h08;
    ca = top >> 1;
    cb = top - 8'h02;
    xfer(1'b1, OFS_CTRL_B, 8'h00);
    xfer(1'b1, OFS_TOP, top);
    xfer(1'b1, OFS_CMP_A, ca);
    xfer(1'b1, OFS_CMP_B, cb);
    xfer(1'b1, OFS_COUNT, 8'h00);
    xfer(1'b1, OFS_CTRL_A, {MODE_CLEAR, MODE_TOGGLE, 4'h3});
    dir <= 1'b1;
    xfer(1'b1, OFS_CTRL_B, 8'h01);
    repeat (40) @(posedge mclk);
    hi_a = 0;
    hi_b = 0;
    for (int i = 0; i < 20 * (top + 1); i++) begin
      @(negedge mclk);
      hi_a += pin_a;
      hi_b += pin_b;
    end
    chk(oa_n, !oa);
    chk(ob_n, !ob);
    chk({oa_n_en, ob_n_en}, 32'h1);
    @(posedge mclk);
    chk_near(hi_a, 20 * ca, 2);
    chk_near(hi_b, 20 * cb, 2);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, OFS_COUNT, 8'h00);
      chk_near(2 * q, top, top);
    end
    $display("test pwm done");
    tally_and_finish();
  end
endmodule // dual_clock_timer_compare_pwm_tb
`default_nettype wire
